// file: bench/frt_ext_clk_model.sv
// Model of the source that drives the external timer clock pin.
// Assumes the CPU clock of the timer; the pin sits low during reset.
`timescale 1ns/1ps
`default_nettype none

module frt_ext_clk_model (
   input  wire logic clk,
   input  wire logic rst_n,
   output var  logic extClk
);
   logic [1:0] phase_ff;
   logic       pin_ff;

   ////////////////////////////////////////////////////////////////////////
   // Toggle every 4 clocks, so like edges stand 8 clocks apart
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_ff <= 2'h0;
         pin_ff   <= 1'b0;
      end else begin
         phase_ff <= phase_ff + 2'h1;
         if (phase_ff == 2'h3) pin_ff <= ~pin_ff;
      end
   end

   assign extClk = pin_ff;
endmodule : frt_ext_clk_model

`default_nettype wire

// file: bench/frt_timer_test.sv
// Self-checking bench for the free-running timer core.
// Assumes frt_pkg, frt_params.svh and the external clock model.
`timescale 1ns/1ps
`default_nettype none

`include "frt_params.svh"

module frt_timer_test
   import frt_pkg::*;
;
   typedef struct packed {
      logic [7:0] ctl;
      frt_pwr_t   pwr;
      logic [7:0] dlt;
   } frt_row_t;

   logic       clk;
   logic       rst_n;
   frt_req_t   busReq;
   logic [7:0] rdData;
   frt_pwr_t   pwrState;
   logic       cpuIntMask;
   logic       extClk;
   logic       timerIrq;
   int         n_fail;
   int         n_checks;
   logic [7:0] a;
   logic [7:0] b;
   frt_row_t   rows [7];

   always #5 clk = ~clk;

   frt_timer uut (
      .clk(clk), .rst_n(rst_n), .busReq(busReq), .rdData(rdData),
      .pwrState(pwrState), .cpuIntMask(cpuIntMask),
      .extClkPin(extClk), .timerIrq(timerIrq)
   );

   frt_ext_clk_model ext (.clk(clk), .rst_n(rst_n), .extClk(extClk));

   ////////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic chk(input string nm, input logic [7:0] s,
                      input logic [7:0] e);
      n_checks++;
      if (s !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   // One-cycle read, data taken in the cycle after
   task automatic rd(input logic [3:0] ad, output logic [7:0] d);
      @(posedge clk);
      busReq <= '{ad, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      busReq.rd <= 1'b0;
      #1 d = rdData;
   endtask : rd

   // One-cycle write
   task automatic wr(input logic [3:0] ad, input logic [7:0] v);
      @(posedge clk);
      busReq <= '{ad, v, 1'b1, 1'b0};
      @(posedge clk);
      busReq.wr <= 1'b0;
   endtask : wr

   // Interrupt line after it has had time to settle
   task automatic irqIs(input logic e);
      repeat (3) @(posedge clk);
      #1 chk("timerIrq", {7'h00, timerIrq}, {7'h00, e});
   endtask : irqIs

   task automatic print_verdict;
      if (n_fail == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict

   ////////////////////////////////////////////////////////////////////////
   // Watchdog far beyond the expected run
   initial begin
      #100000;
      n_fail++;
      print_verdict();
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      busReq = '0;
      pwrState = '0;
      cpuIntMask = 1'b0;
      n_fail = 0;
      n_checks = 0;
      // Clock code, power state, count gained over 24 clocks
      rows[0] = '{8'h00, 2'b00, 8'h0C};
      rows[1] = '{8'h04, 2'b00, 8'h06};
      rows[2] = '{8'h08, 2'b00, 8'h03};
      rows[3] = '{8'h0D, 2'b00, 8'h03};
      rows[4] = '{8'h0C, 2'b00, 8'h03};
      rows[5] = '{8'h00, 2'b10, 8'h0C};
      rows[6] = '{8'h00, 2'b01, 8'h00};
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rd(`FRT_ADDR_CNT_HI, a);
      chk("cntHi", a, 8'hFF);
      rd(`FRT_ADDR_CNT_LO, a);
      chk("cntLo", a, 8'hFC);
      rd(`FRT_ADDR_CTRL2, a);
      chk("ctrl2", a, 8'h00);
      foreach (rows[i]) begin
         wr(`FRT_ADDR_CTRL2, rows[i].ctl);
         @(posedge clk) pwrState <= rows[i].pwr;
         rd(`FRT_ADDR_CTRL2, a);
         chk("ctrl2", a, rows[i].ctl);
         rd(`FRT_ADDR_CNT_LO, a);
         repeat (22) @(posedge clk);
         rd(`FRT_ADDR_CNT_LO, b);
         chk("delta", b - a, rows[i].dlt);
      end
      @(posedge clk) pwrState <= '0;
      // Paired read across both views after a reload
      wr(`FRT_ADDR_CTRL2, 8'h08);
      wr(`FRT_ADDR_ALT_LO, 8'h5A);
      rd(`FRT_ADDR_ALT_HI, a);
      chk("altHi", a, 8'hFF);
      repeat (4) @(posedge clk);
      rd(`FRT_ADDR_CNT_HI, a);
      chk("cntHi", a, 8'hFF);
      rd(`FRT_ADDR_CNT_LO, a);
      chk("heldLo", a, 8'hFC);
      rd(`FRT_ADDR_CNT_LO, a);
      chk("liveLo", a, 8'hFD);
      // Overflow, masking and the two-step clear
      @(posedge clk) cpuIntMask <= 1'b1;
      wr(`FRT_ADDR_CTRL1, 8'h20);
      wr(`FRT_ADDR_CTRL2, 8'h00);
      wr(`FRT_ADDR_CNT_LO, 8'h00);
      repeat (10) @(posedge clk);
      irqIs(1'b0);
      @(posedge clk) cpuIntMask <= 1'b0;
      irqIs(1'b1);
      rd(`FRT_ADDR_CNT_LO, a);
      irqIs(1'b1);
      rd(`FRT_ADDR_STATUS, a);
      chk("status", a, 8'h80);
      rd(`FRT_ADDR_ALT_LO, a);
      irqIs(1'b1);
      rd(`FRT_ADDR_CNT_LO, a);
      irqIs(1'b0);
      rd(`FRT_ADDR_STATUS, a);
      chk("status", a, 8'h00);
      // Reset while halted: count restarts from the reload value
      @(posedge clk) pwrState <= 2'b01;
      repeat (3) @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n    <= 1'b1;
      pwrState <= '0;
      rd(`FRT_ADDR_CNT_HI, a);
      chk("rstHi", a, 8'hFF);
      rd(`FRT_ADDR_CNT_LO, a);
      chk("rstLo", a, 8'hFC);
      rd(`FRT_ADDR_CTRL1, a);
      chk("rstCtrl1", a, 8'h00);
      rd(4'hF, a);
      chk("unmapped", a, 8'h00);
      print_verdict();
   end
endmodule : frt_timer_test

`default_nettype wire

// file: hw/frt_params.svh
// Constants for the free-running timer core: offsets, fields, reset values.
// Assumes inclusion by the package, the timer module and the test bench.
`ifndef FRT_PARAMS_SVH
`define FRT_PARAMS_SVH

// Register indexes on the byte-wide register port
`define FRT_ADDR_CNT_HI    4'h0
`define FRT_ADDR_CNT_LO    4'h1
`define FRT_ADDR_ALT_HI    4'h2
`define FRT_ADDR_ALT_LO    4'h3
`define FRT_ADDR_STATUS    4'h4
`define FRT_ADDR_CTRL1     4'h5
`define FRT_ADDR_CTRL2     4'h6

// Counter values
`define FRT_CNT_RELOAD     16'hFFFC
`define FRT_CNT_MAX        16'hFFFF
`define FRT_CNT_ONE        16'h0001

// Field positions
`define FRT_SR_OVF_BIT     7
`define FRT_CR1_OVIE_BIT   5
`define FRT_CR2_CSEL_LO    2
`define FRT_CR2_EDGE_BIT   0

// Clock-select codes (external is both bits one)
`define FRT_CSEL_DIV2      2'h0
`define FRT_CSEL_DIV4      2'h1
`define FRT_CSEL_DIV8      2'h2
`define FRT_CSEL_EXT       2'h3

// Prescaler terminal counts
`define FRT_PRE_DIV2       3'h1
`define FRT_PRE_DIV4       3'h3
`define FRT_PRE_DIV8       3'h7
`define FRT_PRE_ZERO       3'h0
`define FRT_BYTE_ZERO      8'h00

`endif

// file: hw/frt_pkg.sv
// Types shared by the free-running timer core.
// Assumes frt_params.svh is on the include path.
package frt_pkg;
   `include "frt_params.svh"

   // Register port request from the CPU side
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } frt_req_t;

   // Power state of the CPU
   typedef struct packed {
      logic waitMode;
      logic haltMode;
   } frt_pwr_t;

   // Overflow clear sequence state
   typedef enum logic [0:0] {
      FRT_CLR_IDLE,
      FRT_CLR_ARMED
   } frt_clr_t;
endpackage : frt_pkg

// file: hw/frt_timer.sv
// Free-running 16-bit timer core with byte-wide register port.
// Assumes one 100 MHz CPU clock, async active-low reset, and an
// external timer clock pin that is asynchronous to clk.
//
// Operation
// - 16-bit up-counter, one step per timer tick
// - Control register picks div 2/4/8 or external
// - Each view split into high and low bytes
// - Two views same count; alternate never clears flag
// - Low-byte write reloads counter with FFFC
// - Reset start value FFFC, the only reload
// - High-byte read latches low byte for later
// - Latched low byte frozen until low read
// - Unpaired low read returns live low byte
// - Wrap FFFF to 0000 sets overflow flag
// - Interrupt when enabled and CPU unmasked
// - Flag clears: status read, then main low access
// - Counter runs on in wait mode
// - Halt freezes counter, resumes from frozen count
// - Both select bits one picks external, edge chosen
// - External advances synchronised to CPU clock
`timescale 1ns/1ps
`default_nettype none

`include "frt_params.svh"

module frt_timer
   import frt_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire frt_req_t   busReq,
   output var  logic [7:0] rdData,
   input  wire frt_pwr_t   pwrState,
   input  wire logic       cpuIntMask,
   input  wire logic       extClkPin,
   output var  logic       timerIrq
);

   ////////////////////////////////////////////////////////////////////////
   // Address decode
   wire rdCntHi  = busReq.rd && (busReq.addr == `FRT_ADDR_CNT_HI);
   wire rdCntLo  = busReq.rd && (busReq.addr == `FRT_ADDR_CNT_LO);
   wire rdAltHi  = busReq.rd && (busReq.addr == `FRT_ADDR_ALT_HI);
   wire rdAltLo  = busReq.rd && (busReq.addr == `FRT_ADDR_ALT_LO);
   wire rdStatus = busReq.rd && (busReq.addr == `FRT_ADDR_STATUS);
   wire wrCntLo  = busReq.wr && (busReq.addr == `FRT_ADDR_CNT_LO);
   wire wrAltLo  = busReq.wr && (busReq.addr == `FRT_ADDR_ALT_LO);
   wire wrCtrl1  = busReq.wr && (busReq.addr == `FRT_ADDR_CTRL1);
   wire wrCtrl2  = busReq.wr && (busReq.addr == `FRT_ADDR_CTRL2);
   // Any high or low read of either view
   wire rdHigh   = rdCntHi || rdAltHi;
   wire rdLow    = rdCntLo || rdAltLo;
   // Main low byte accessed by read or write
   wire mainLoAccess = rdCntLo || wrCntLo;
   // Reload from either low-byte write
   wire reloadReq    = wrCntLo || wrAltLo;

   ////////////////////////////////////////////////////////////////////////
   // Control registers
   logic [7:0] ctrl1_ff;
   logic [7:0] ctrl2_ff;

   // Software-written control bytes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl1_ff <= `FRT_BYTE_ZERO;
         ctrl2_ff <= `FRT_BYTE_ZERO;
      end else begin
         if (wrCtrl1)
            ctrl1_ff <= busReq.wdata;
         if (wrCtrl2)
            ctrl2_ff <= busReq.wdata;
      end
   end

   wire [1:0] clkSel  = ctrl2_ff[`FRT_CR2_CSEL_LO +: 2];
   wire       edgeSel = ctrl2_ff[`FRT_CR2_EDGE_BIT];
   wire       ovfIe   = ctrl1_ff[`FRT_CR1_OVIE_BIT];
   wire       useExt  = (clkSel == `FRT_CSEL_EXT);

   ////////////////////////////////////////////////////////////////////////
   // External pin synchroniser and edge detect
   logic extSync1_ff;
   logic extSync2_ff;
   logic extPrev_ff;

   // Two-flop sync, then a third flop for the edge
   // Only the second and third flops feed logic; the first may be metastable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         extSync1_ff <= 1'b0;
         extSync2_ff <= 1'b0;
         extPrev_ff  <= 1'b0;
      end else begin
         extSync1_ff <= extClkPin;
         extSync2_ff <= extSync1_ff;
         extPrev_ff  <= extSync2_ff;
      end
   end

   // Rising when edge bit set, falling otherwise; relies on slow pin
   wire extRise = extSync2_ff && !extPrev_ff;
   wire extFall = !extSync2_ff && extPrev_ff;
   wire extTick = useExt && (edgeSel ? extRise : extFall);

   ////////////////////////////////////////////////////////////////////////
   // Prescaler
   logic [2:0] pre_ff;

   // Terminal count for the selected divider
   function automatic logic [2:0] preLimit(input logic [1:0] sel);
      case (sel)
         `FRT_CSEL_DIV2: preLimit = `FRT_PRE_DIV2;
         `FRT_CSEL_DIV4: preLimit = `FRT_PRE_DIV4;
         `FRT_CSEL_DIV8: preLimit = `FRT_PRE_DIV8;
         default:        preLimit = `FRT_PRE_ZERO;
      endcase
   endfunction : preLimit

   wire       frozen  = pwrState.haltMode;
   wire       preWrap = (pre_ff >= preLimit(clkSel));
   wire       intTick = !useExt && preWrap;
   wire       tick    = !frozen && (intTick || extTick);
   wire [2:0] nxt_pre = (preWrap || useExt) ? `FRT_PRE_ZERO
                                            : pre_ff + 3'h1;

   // Prescaler halts with the counter
   // A low-byte write also restarts the divider phase
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         pre_ff <= `FRT_PRE_ZERO;
      else if (reloadReq)
         pre_ff <= `FRT_PRE_ZERO;
      else if (!frozen)
         pre_ff <= nxt_pre;
   end

   ////////////////////////////////////////////////////////////////////////
   // Counter
   logic [15:0] cnt_ff;
   // A reload in the same cycle wins: no wrap, no flag
   wire         wrapNow = tick && !reloadReq
                        && (cnt_ff == `FRT_CNT_MAX);
   wire [15:0]  nxt_cnt = reloadReq ? `FRT_CNT_RELOAD
                        : tick ? cnt_ff + `FRT_CNT_ONE
                        : cnt_ff;

   // Reset and reload both go to the single reload value
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         cnt_ff <= `FRT_CNT_RELOAD;
      else
         cnt_ff <= nxt_cnt;
   end

   ////////////////////////////////////////////////////////////////////////
   // Buffered 16-bit read
   logic [7:0] loBuf_ff;
   logic       loHeld_ff;

   // First high read latches low byte; low read releases it
   // Either view's high read arms the one shared buffer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         loBuf_ff  <= `FRT_BYTE_ZERO;
         loHeld_ff <= 1'b0;
      end else if (rdHigh && !loHeld_ff) begin
         loBuf_ff  <= cnt_ff[7:0];
         loHeld_ff <= 1'b1;
      end else if (rdLow) begin
         loHeld_ff <= 1'b0;
      end
   end

   wire [7:0] loView = loHeld_ff ? loBuf_ff : cnt_ff[7:0];

   ////////////////////////////////////////////////////////////////////////
   // Overflow flag and two-step clear
   logic     ovf_ff;
   frt_clr_t clr_ff;
   frt_clr_t nxt_clr;

   // Arm on status read with flag set; fire on main low access
   always_comb begin
      nxt_clr = clr_ff;
      case (clr_ff)
         FRT_CLR_IDLE:
            if (rdStatus && ovf_ff)
               nxt_clr = FRT_CLR_ARMED;
         FRT_CLR_ARMED:
            if (mainLoAccess)
               nxt_clr = FRT_CLR_IDLE;
         default:
            nxt_clr = FRT_CLR_IDLE;
      endcase
   end

   wire clrFire = (clr_ff == FRT_CLR_ARMED) && mainLoAccess;

   // Set wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ovf_ff <= 1'b0;
         clr_ff <= FRT_CLR_IDLE;
      end else begin
         clr_ff <= nxt_clr;
         if (wrapNow)
            ovf_ff <= 1'b1;
         else if (clrFire)
            ovf_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data and interrupt outputs
   wire [7:0] statusByte = {ovf_ff, 7'h00};
   wire [7:0] nxt_rd =
        (rdCntHi || rdAltHi) ? cnt_ff[15:8]
      : (rdCntLo || rdAltLo) ? loView
      : rdStatus             ? statusByte
      : (busReq.rd && busReq.addr == `FRT_ADDR_CTRL1) ? ctrl1_ff
      : (busReq.rd && busReq.addr == `FRT_ADDR_CTRL2) ? ctrl2_ff
      : `FRT_BYTE_ZERO;
   wire nxt_irq = ovf_ff && ovfIe && !cpuIntMask;

   // Registered outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdData   <= `FRT_BYTE_ZERO;
         timerIrq <= 1'b0;
      end else begin
         rdData   <= nxt_rd;
         timerIrq <= nxt_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_statusArm;
      rdStatus && ovf_ff;
   endsequence

   sequence s_mainLo;
      mainLoAccess && !wrapNow;
   endsequence

   a_wrap_sets_flag: assert property (@(posedge clk)
      disable iff (!rst_n) wrapNow |=> ovf_ff && cnt_ff == 16'h0000)
      else $error("overflow flag not set on wrap");

   a_reload_value: assert property (@(posedge clk) disable iff (!rst_n)
      reloadReq |=> cnt_ff == `FRT_CNT_RELOAD)
      else $error("counter not reloaded");

   a_tick_step: assert property (@(posedge clk) disable iff (!rst_n)
      (tick && !reloadReq) |=> cnt_ff == $past(cnt_ff) + 16'h0001)
      else $error("counter did not advance");

   a_halt_freeze: assert property (@(posedge clk) disable iff (!rst_n)
      (frozen && !reloadReq) |=> $stable(cnt_ff))
      else $error("counter moved in halt");

   a_div2_rate: assert property (@(posedge clk) disable iff (!rst_n)
      (tick && clkSel == `FRT_CSEL_DIV2 && !frozen && !reloadReq
       && !wrCtrl2) |=> !tick ##1 (tick || frozen || $past(frozen)
       || $past(reloadReq) || $past(wrCtrl2)))
      else $error("divide by two rate wrong");

   a_buf_frozen: assert property (@(posedge clk) disable iff (!rst_n)
      (loHeld_ff && !rdLow) |=> $stable(loBuf_ff) && loHeld_ff)
      else $error("latched low byte changed");

   a_hi_latch: assert property (@(posedge clk) disable iff (!rst_n)
      (rdHigh && !loHeld_ff) |=> loBuf_ff == $past(cnt_ff[7:0]))
      else $error("low byte not latched");

   a_live_low: assert property (@(posedge clk) disable iff (!rst_n)
      (rdLow && !loHeld_ff) |=> rdData == $past(cnt_ff[7:0]))
      else $error("unpaired low read not live");

   a_two_step_clr: assert property (@(posedge clk)
      disable iff (!rst_n)
      s_statusArm ##1 (!mainLoAccess && !wrapNow) [*6] ##1 s_mainLo
      |=> !ovf_ff)
      else $error("overflow flag not cleared");

   a_alt_keeps: assert property (@(posedge clk) disable iff (!rst_n)
      (ovf_ff && !mainLoAccess) |=> ovf_ff)
      else $error("flag cleared without main low access");

   a_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
      timerIrq |-> $past(ovf_ff) && $past(ovfIe) && !$past(cpuIntMask))
      else $error("interrupt without enable");

   a_ext_only: assert property (@(posedge clk) disable iff (!rst_n)
      (useExt && tick) |-> (extRise || extFall))
      else $error("external tick without pin edge");

   ////////////////////////////////////////////////////////////////////////
   // Read path checks
   a_high_read: assert property (@(posedge clk) disable iff (!rst_n)
      rdHigh |=> rdData == $past(cnt_ff[15:8]))
      else $error("high byte read wrong");

   a_held_low: assert property (@(posedge clk) disable iff (!rst_n)
      (rdLow && loHeld_ff) |=> rdData == $past(loBuf_ff))
      else $error("paired low read not from buffer");

   a_status_read: assert property (@(posedge clk) disable iff (!rst_n)
      rdStatus |=> rdData == {$past(ovf_ff), 7'h00})
      else $error("status byte wrong");

   ////////////////////////////////////////////////////////////////////////
   // Interrupt, power and clock checks
   sequence s_wrongEdge;
      useExt && (edgeSel ? extFall : extRise);
   endsequence

   a_irq_follow: assert property (@(posedge clk) disable iff (!rst_n)
      (ovf_ff && ovfIe && !cpuIntMask) |=> timerIrq)
      else $error("pending interrupt not raised");

   a_irq_pending: assert property (@(posedge clk) disable iff (!rst_n)
      (ovf_ff && ovfIe && cpuIntMask) |=> !timerIrq)
      else $error("interrupt raised while masked");

   a_wait_runs: assert property (@(posedge clk) disable iff (!rst_n)
      (pwrState.waitMode && !pwrState.haltMode && intTick) |-> tick)
      else $error("counter stopped in wait mode");

   a_wrong_edge: assert property (@(posedge clk) disable iff (!rst_n)
      s_wrongEdge |-> !tick)
      else $error("counter advanced on unselected edge");

   a_div8_rate: assert property (@(posedge clk) disable iff (!rst_n)
      (tick && clkSel == `FRT_CSEL_DIV8)
      |=> (!tick || clkSel != `FRT_CSEL_DIV8) [*7])
      else $error("divide by eight rate wrong");

endmodule : frt_timer

`default_nettype wire
